// file: sst_pkg.sv
/*
 * Package for the synchronization and trigger unit: register map,
 * field positions, reset values, timing constants and carrier types.
 * Assumes a single 20 MHz clock and a simple strobe register port.
 */
package sst_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned BASE_HZ         = 400;
    localparam int unsigned BASE_CYC        = CLK_HZ / BASE_HZ;
    localparam int unsigned US_CYC          = CLK_HZ / 1_000_000;
    localparam int unsigned SAMPLE_HZ       = 10_000;
    localparam int unsigned SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned FIRST_SMP_US    = 690;
    localparam int unsigned FIRST_IMU_US    = 3190;
    localparam int unsigned FIRST_ORI_US    = 10690;
    localparam int unsigned FIRST_SMP_CYC   = FIRST_SMP_US * US_CYC;
    localparam int unsigned FIRST_IMU_CYC   = FIRST_IMU_US * US_CYC;
    localparam int unsigned FIRST_ORI_CYC   = FIRST_ORI_US * US_CYC;
    localparam int unsigned HOLDOVER_S      = 30;
    localparam int unsigned HOLDOVER_CYC    = HOLDOVER_S * CLK_HZ;
    localparam int unsigned INIT_US_PER_PPM = 720;
    localparam int unsigned INIT_CYC_PER_PPM = INIT_US_PER_PPM * US_CYC;
    localparam int unsigned MAX_PPM         = 900;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_TRIG_DLY = 4'h1;
    localparam logic [3:0] OFS_SKIP     = 4'h2;
    localparam logic [3:0] OFS_WIDTH    = 4'h3;
    localparam logic [3:0] OFS_OFFSET   = 4'h4;
    localparam logic [3:0] OFS_REF_PER  = 4'h5;
    localparam logic [3:0] OFS_START_DLY = 4'h6;
    localparam logic [3:0] OFS_STATUS   = 4'h7;
    localparam logic [3:0] OFS_BIAS     = 4'h8;
    localparam logic [3:0] OFS_MARK_TS  = 4'h9;
    localparam logic [3:0] OFS_POLL     = 4'hA;

    // ****************************************************************
    // Control field positions and reset values
    // ****************************************************************
    localparam int unsigned CB_SEND_LATEST = 0;
    localparam int unsigned CB_TRIG_FALL   = 1;
    localparam int unsigned CB_MARKER_EN   = 2;
    localparam int unsigned CB_PULSE_EN    = 3;
    localparam int unsigned CB_TOGGLE      = 4;
    localparam int unsigned CB_POL_NEG     = 5;
    localparam int unsigned CB_DRIFT_EN    = 6;
    localparam int unsigned CB_START_EN    = 7;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] CTRL_RST_GNSS  = 16'h0040;
    localparam logic [15:0] SKIP_RST       = 16'h0004;
    localparam logic [15:0] WIDTH_RST      = 16'h03E8;
    localparam logic [15:0] REF_PER_RST    = 16'h03E8;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } sst_req_t;

    // Data-path event towards the message builder
    typedef struct packed {
        logic        send;
        logic        marker;
        logic        out_mark;
        logic [31:0] out_time;
    } sst_evt_t;

endpackage : sst_pkg

// file: sst_edge.sv
/*
 * Two-flop synchroniser with selectable edge detect for the trigger input.
 * Assumes the input may be asynchronous to mclk.
 */
module sst_edge (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Line and edge select
    input  wire logic line_in,
    input  wire logic fall_sel,
    // Single-cycle event
    output logic      edge_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Three flops; the first is never looked at
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= line_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // One pulse per chosen edge
    assign edge_pulse = fall_sel ? (last_reg & ~sync_reg) : (~last_reg & sync_reg);

endmodule : sst_edge

// file: sst_top.sv
/*
 * Synchronization and trigger unit: send-latest triggering, trigger
 * marking, periodic output pulses, drift correction, start sampling.
 * Assumes a 20 MHz mclk and registers reached over a strobe port.
 */
module sst_top #(
    parameter bit          GNSS_VARIANT = 1'b0,
    parameter int unsigned HOLDOVER     = sst_pkg::HOLDOVER_CYC,
    parameter int unsigned FIRST_SMP    = sst_pkg::FIRST_SMP_CYC,
    parameter int unsigned FIRST_IMU    = sst_pkg::FIRST_IMU_CYC,
    parameter int unsigned FIRST_ORI    = sst_pkg::FIRST_ORI_CYC,
    parameter int unsigned US_CYC       = sst_pkg::US_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Pins
    input  wire logic        sync_input_line,
    input  wire logic        sampling_start_sync,
    input  wire logic        clock_ref_pulse,
    output logic             sync_output_line,
    // Sample source and message builder
    input  wire logic        sample_ready,
    input  wire logic [31:0] sample_data,
    output logic             send_strobe,
    output logic [31:0]      send_data,
    output logic [15:0]      status_word,
    output logic [31:0]      out_mark_time,
    output logic             out_mark_valid,
    // Sampling pipeline and calibration
    output logic             first_sample,
    output logic             first_inertial,
    output logic             first_orient,
    output logic [31:0]      clock_bias,
    output logic             drift_locked
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    sst_pkg::sst_req_t req;
    logic [15:0] ctrl_reg, trig_dly_reg, skip_reg, width_reg, offset_reg, ref_per_reg;
    logic [15:0] start_dly_reg;
    logic        poll_req;
    logic [31:0] rd_next;
    logic [31:0] time_reg;
    logic        marker_flag_reg, send_pend_reg, mark_pend_reg;
    logic        out_level_reg;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign poll_req = req.wr && req.addr == sst_pkg::OFS_POLL;

    // Configuration writes; all functions share one clock so they coexist
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg      <= GNSS_VARIANT ? sst_pkg::CTRL_RST_GNSS : sst_pkg::CTRL_RST;
            trig_dly_reg  <= 16'h0000;
            skip_reg      <= sst_pkg::SKIP_RST;
            width_reg     <= sst_pkg::WIDTH_RST;
            offset_reg    <= 16'h0000;
            ref_per_reg   <= sst_pkg::REF_PER_RST;
            start_dly_reg <= 16'h0000;
        end else if (req.wr) begin
            unique case (req.addr)
                sst_pkg::OFS_CTRL:      ctrl_reg      <= req.wdata[15:0];
                sst_pkg::OFS_TRIG_DLY:  trig_dly_reg  <= req.wdata[15:0];
                sst_pkg::OFS_SKIP:      skip_reg      <= req.wdata[15:0];
                sst_pkg::OFS_WIDTH:     width_reg     <= req.wdata[15:0];
                sst_pkg::OFS_OFFSET:    offset_reg    <= req.wdata[15:0];
                sst_pkg::OFS_REF_PER:   ref_per_reg   <= req.wdata[15:0];
                sst_pkg::OFS_START_DLY: start_dly_reg <= req.wdata[15:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (req.addr)
            sst_pkg::OFS_CTRL:      rd_next = {16'h0000, ctrl_reg};
            sst_pkg::OFS_TRIG_DLY:  rd_next = {16'h0000, trig_dly_reg};
            sst_pkg::OFS_SKIP:      rd_next = {16'h0000, skip_reg};
            sst_pkg::OFS_WIDTH:     rd_next = {16'h0000, width_reg};
            sst_pkg::OFS_OFFSET:    rd_next = {16'h0000, offset_reg};
            sst_pkg::OFS_REF_PER:   rd_next = {16'h0000, ref_per_reg};
            sst_pkg::OFS_START_DLY: rd_next = {16'h0000, start_dly_reg};
            sst_pkg::OFS_STATUS:    rd_next = {27'h0, drift_locked, out_level_reg,
                                               mark_pend_reg, send_pend_reg, marker_flag_reg};
            sst_pkg::OFS_BIAS:      rd_next = clock_bias;
            sst_pkg::OFS_MARK_TS:   rd_next = out_mark_time;
            default:                rd_next = 32'h0000_0000;
        endcase
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (rst) reg_rdata <= 32'h0000_0000;
        else     reg_rdata <= req.rd ? rd_next : 32'h0000_0000;
    end

    // ****************************************************************
    // Timebase: microsecond tick and free-running cycle timestamp
    // ****************************************************************
    logic [7:0] us_cnt_reg;
    logic       us_tick;
    assign us_tick = us_cnt_reg == 8'(US_CYC - 1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            us_cnt_reg <= 8'h00;
            time_reg   <= 32'h0000_0000;
        end else begin
            us_cnt_reg <= us_tick ? 8'h00 : us_cnt_reg + 8'h01;
            time_reg   <= time_reg + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // Send latest and trigger marker
    // ****************************************************************
    logic        trig_edge;
    logic [31:0] latest_reg;
    logic [15:0] tdly_cnt_reg;

    sst_edge u_edge (
        .mclk       (mclk),
        .rst        (rst),
        .line_in    (sync_input_line),
        .fall_sel   (ctrl_reg[sst_pkg::CB_TRIG_FALL]),
        .edge_pulse (trig_edge)
    );

    // Holds the newest sample; a trigger never waits for a fresh one
    always_ff @(posedge mclk) begin
        if (rst)               latest_reg <= 32'h0000_0000;
        else if (sample_ready) latest_reg <= sample_data;
    end

    // Trigger latched once, then sent after the programmed delay in us
    always_ff @(posedge mclk) begin
        if (rst) begin
            send_pend_reg <= 1'b0;
            tdly_cnt_reg  <= 16'h0000;
        end else if ((trig_edge && ctrl_reg[sst_pkg::CB_SEND_LATEST]) || poll_req) begin
            send_pend_reg <= 1'b1;
            tdly_cnt_reg  <= trig_dly_reg;
        end else if (send_pend_reg && us_tick) begin
            if (tdly_cnt_reg == 16'h0000) send_pend_reg <= 1'b0;
            else                          tdly_cnt_reg  <= tdly_cnt_reg - 16'h0001;
        end
    end

    // Message strobe carries the latest sample, unaltered
    always_ff @(posedge mclk) begin
        if (rst) begin
            send_strobe <= 1'b0;
            send_data   <= 32'h0000_0000;
        end else begin
            send_strobe <= send_pend_reg && us_tick && tdly_cnt_reg == 16'h0000;
            send_data   <= latest_reg;
        end
    end

    // Marker flag: a pulse in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (rst)
            marker_flag_reg <= 1'b0;
        else if (trig_edge && ctrl_reg[sst_pkg::CB_MARKER_EN])
            marker_flag_reg <= 1'b1;
        else if (send_strobe)
            marker_flag_reg <= 1'b0;
    end
    assign status_word = {15'h0000, marker_flag_reg};

    // ****************************************************************
    // Periodic output pulse on the 400 Hz grid
    // ****************************************************************
    logic [15:0] base_cnt_reg, skip_cnt_reg, off_cnt_reg, wid_cnt_reg;
    logic        base_tick, off_arm_reg, pulse_on_reg;

    assign base_tick = base_cnt_reg == 16'(sst_pkg::BASE_CYC - 1);

    // Base grid counter from the internal clock only
    always_ff @(posedge mclk) begin
        if (rst)            base_cnt_reg <= 16'h0000;
        else if (base_tick) base_cnt_reg <= 16'h0000;
        else                base_cnt_reg <= base_cnt_reg + 16'h0001;
    end

    // Every skip+1 base ticks arm the offset timer
    always_ff @(posedge mclk) begin
        if (rst || !ctrl_reg[sst_pkg::CB_PULSE_EN]) begin
            skip_cnt_reg <= 16'h0000;
            off_arm_reg  <= 1'b0;
            off_cnt_reg  <= 16'h0000;
        end else if (base_tick && skip_cnt_reg == 16'h0000) begin
            skip_cnt_reg <= skip_reg;
            off_arm_reg  <= 1'b1;
            off_cnt_reg  <= offset_reg;
        end else begin
            if (base_tick) skip_cnt_reg <= skip_cnt_reg - 16'h0001;
            if (off_arm_reg && us_tick) begin
                if (off_cnt_reg == 16'h0000) off_arm_reg <= 1'b0;
                else                         off_cnt_reg <= off_cnt_reg - 16'h0001;
            end
        end
    end

    logic pulse_start;
    assign pulse_start = off_arm_reg && us_tick && off_cnt_reg == 16'h0000;

    // Width timer in microseconds; toggle mode flips once per period
    always_ff @(posedge mclk) begin
        if (rst) begin
            pulse_on_reg  <= 1'b0;
            wid_cnt_reg   <= 16'h0000;
            out_level_reg <= 1'b0;
        end else if (pulse_start) begin
            pulse_on_reg  <= !ctrl_reg[sst_pkg::CB_TOGGLE] && width_reg != 16'h0000;
            wid_cnt_reg   <= width_reg - 16'h0001;
            out_level_reg <= ctrl_reg[sst_pkg::CB_TOGGLE] ? ~out_level_reg : out_level_reg;
        end else if (pulse_on_reg && us_tick) begin
            if (wid_cnt_reg == 16'h0000) pulse_on_reg <= 1'b0;
            else                         wid_cnt_reg  <= wid_cnt_reg - 16'h0001;
        end
    end

    // Output level from a flop so the pin never glitches
    always_ff @(posedge mclk) begin
        if (rst)
            sync_output_line <= 1'b0;
        else if (ctrl_reg[sst_pkg::CB_TOGGLE])
            sync_output_line <= out_level_reg;
        else
            sync_output_line <= pulse_on_reg ^ ctrl_reg[sst_pkg::CB_POL_NEG];
    end

    // Timestamp of each output pulse start for the data stream
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_mark_time  <= 32'h0000_0000;
            out_mark_valid <= 1'b0;
            mark_pend_reg  <= 1'b0;
        end else begin
            out_mark_valid <= pulse_start;
            if (pulse_start) out_mark_time <= time_reg;
            if (pulse_start)      mark_pend_reg <= 1'b1;
            else if (send_strobe) mark_pend_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Clock drift correction
    // ****************************************************************
    logic        ref_edge, ref_last_reg, ref_seen_reg;
    logic [31:0] ref_cnt_reg, hold_cnt_reg;
    logic [31:0] expect_cyc;

    // Reference assumed 0.1-1000 Hz and within 900 ppm
    assign expect_cyc = 32'(ref_per_reg) * 32'(sst_pkg::US_CYC) * 32'd1000;
    assign ref_edge   = clock_ref_pulse & ~ref_last_reg;

    always_ff @(posedge mclk) begin
        if (rst) ref_last_reg <= 1'b0;
        else     ref_last_reg <= clock_ref_pulse;
    end

    // Bias follows measured period; bias stays put when pulses drop
    always_ff @(posedge mclk) begin
        if (rst || !ctrl_reg[sst_pkg::CB_DRIFT_EN]) begin
            ref_cnt_reg  <= 32'h0000_0000;
            hold_cnt_reg <= 32'h0000_0000;
            ref_seen_reg <= 1'b0;
            clock_bias   <= 32'h0000_0000;
            drift_locked <= 1'b0;
        end else if (ref_edge) begin
            ref_cnt_reg  <= 32'h0000_0001; // Edge cycle counts, so a true period reads exact
            hold_cnt_reg <= 32'h0000_0000;
            ref_seen_reg <= 1'b1;
            if (ref_seen_reg) begin
                clock_bias   <= ref_cnt_reg - expect_cyc;
                drift_locked <= 1'b1;
            end
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 32'h0000_0001;
            if (hold_cnt_reg >= 32'(HOLDOVER)) begin
                drift_locked <= 1'b0; // holdover expired
                ref_seen_reg <= 1'b0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // Start sampling with programmable delay
    // ****************************************************************
    logic        start_last_reg, start_run_reg;
    logic [31:0] start_cnt_reg, dly_cyc;

    assign dly_cyc = 32'(start_dly_reg) * 32'(US_CYC);

    always_ff @(posedge mclk) begin
        if (rst) start_last_reg <= 1'b0;
        else     start_last_reg <= sampling_start_sync;
    end

    // Milestones counted from the start pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            start_run_reg  <= 1'b0;
            start_cnt_reg  <= 32'h0000_0000;
            first_sample   <= 1'b0;
            first_inertial <= 1'b0;
            first_orient   <= 1'b0;
        end else begin
            first_sample   <= start_run_reg && start_cnt_reg == 32'(FIRST_SMP) + dly_cyc;
            first_inertial <= start_run_reg && start_cnt_reg == 32'(FIRST_IMU) + dly_cyc;
            first_orient   <= start_run_reg && start_cnt_reg == 32'(FIRST_ORI) + dly_cyc;
            if (sampling_start_sync && !start_last_reg && ctrl_reg[sst_pkg::CB_START_EN]) begin
                start_run_reg <= 1'b1;
                start_cnt_reg <= 32'h0000_0000;
            end else if (start_run_reg) begin
                start_cnt_reg <= start_cnt_reg + 32'h0000_0001;
                if (start_cnt_reg > 32'(FIRST_ORI) + dly_cyc) start_run_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_poll_send;
        @(posedge mclk) disable iff (rst)
        (poll_req && trig_dly_reg == 16'h0000) |-> ##[1:25] send_strobe;
    endproperty
    a_poll_send: assert property (p_poll_send) else $error("poll not sent");

    property p_no_spont_send;
        @(posedge mclk) disable iff (rst)
        (!send_pend_reg) |=> !send_strobe;
    endproperty
    a_no_spont_send: assert property (p_no_spont_send) else $error("send w/o trig");

    property p_marker;
        @(posedge mclk) disable iff (rst)
        (trig_edge && ctrl_reg[sst_pkg::CB_MARKER_EN]) |=> status_word[0];
    endproperty
    a_marker: assert property (p_marker) else $error("marker missing");

    property p_data_kept;
        @(posedge mclk) disable iff (rst)
        send_strobe |-> send_data == $past(latest_reg);
    endproperty
    a_data_kept: assert property (p_data_kept) else $error("data altered");

    property p_base_grid;
        @(posedge mclk) disable iff (rst)
        base_tick |=> base_cnt_reg == 16'h0000;
    endproperty
    a_base_grid: assert property (p_base_grid) else $error("grid wrong");

    property p_mark_time;
        @(posedge mclk) disable iff (rst)
        pulse_start |=> out_mark_valid && out_mark_time == $past(time_reg);
    endproperty
    a_mark_time: assert property (p_mark_time) else $error("mark time wrong");

    property p_polarity;
        @(posedge mclk) disable iff (rst)
        (!ctrl_reg[sst_pkg::CB_TOGGLE] && !pulse_on_reg) |=>
            sync_output_line == $past(ctrl_reg[sst_pkg::CB_POL_NEG]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("idle level wrong");

    property p_lock_drop;
        @(posedge mclk) disable iff (rst)
        (!ctrl_reg[sst_pkg::CB_DRIFT_EN]) |=> !drift_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock while off");

    c_poll:   cover property (@(posedge mclk) disable iff (rst) send_strobe);
    c_pulse:  cover property (@(posedge mclk) disable iff (rst) out_mark_valid);
    c_lock:   cover property (@(posedge mclk) disable iff (rst) drift_locked);
    c_start:  cover property (@(posedge mclk) disable iff (rst) first_orient);

endmodule : sst_top

// file: sst_far_model.sv
/* Far-side model: sample source and drift reference generator.
   Assumes mclk drives it; hold freezes the sample stream. */
module sst_far_model (
    // Clock and control
    input  wire logic   mclk,
    input  wire logic   hold,
    // Toward the unit
    output logic        sample_ready,
    output logic [31:0] sample_data,
    output logic        clock_ref_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // New sample every 40 cycles; 1 kHz reference, the top of the legal band
    always @(posedge mclk) begin
        cnt <= cnt + 1;
        sample_ready <= !hold && (cnt % 40 == 0);
        if (cnt == 0) sample_data <= 32'h0000_0000;
        else if (!hold && cnt % 40 == 0) sample_data <= sample_data + 32'h0000_0011;
        clock_ref_pulse <= (cnt % 20000) < 10;
    end
endmodule : sst_far_model

// file: tb.sv
/* Testbench: register reads, poll, trigger, output pulse, start sampling.
   Assumes the far-side model supplies samples and the reference. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst, reg_wr, reg_rd, hold, sync_input_line, sampling_start_sync;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, sample_data, send_data, out_mark_time, clock_bias;
    logic [15:0] status_word;
    logic        clock_ref_pulse, sync_output_line, sample_ready, send_strobe, out_mark_valid;
    logic        first_sample, first_inertial, first_orient, drift_locked;
    int          num_errors = 0;
    int          num_checks = 0;
    int          n, n0;
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Short start milestones keep the run brief
    sst_top #(.HOLDOVER(30000), .FIRST_SMP(10), .FIRST_IMU(20), .FIRST_ORI(40)) DUT (
        .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sync_input_line, .sampling_start_sync, .clock_ref_pulse, .sync_output_line,
        .sample_ready, .sample_data, .send_strobe, .send_data, .status_word,
        .out_mark_time, .out_mark_valid, .first_sample, .first_inertial,
        .first_orient, .clock_bias, .drift_locked);
    sst_far_model far (.mclk, .hold, .sample_ready, .sample_data, .clock_ref_pulse);
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        check(nm, reg_rdata, e);
    endtask : rd
    // Bounded wait; n ends as the number of edges waited
    task automatic wait_hi(input string nm, ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge mclk);
            n++;
        end
        check(nm, s, 1'b1);
    endtask : wait_hi
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Watchdog well beyond the expected 50k cycles
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        test_done();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 38'h0};
        {hold, sync_input_line, sampling_start_sync} = 3'b000;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd("ctrl", sst_pkg::OFS_CTRL, 32'h0);
        rd("skip", sst_pkg::OFS_SKIP, 32'h4);
        rd("width", sst_pkg::OFS_WIDTH, 32'h3E8);
        rd("unmapped", 4'hB, 32'h0);
        $display("test regs done");
        hold <= 1'b1;
        repeat (50) @(posedge mclk);
        wr(sst_pkg::OFS_POLL, 32'h0);
        wait_hi("poll", send_strobe, 60);
        n0 = n;
        check("latest", send_data, sample_data);
        wr(sst_pkg::OFS_TRIG_DLY, 32'h5);
        wr(sst_pkg::OFS_POLL, 32'h0);
        wait_hi("delayed", send_strobe, 200);
        check("delay", 32'(n - n0 >= 79 && n - n0 <= 121), 32'h1);
        wr(sst_pkg::OFS_TRIG_DLY, 32'h0);
        hold <= 1'b0;
        wr(sst_pkg::OFS_CTRL, 32'h5);
        n = 0;
        repeat (2000) begin
            @(posedge mclk);
            if (send_strobe === 1'b1) n++;
        end
        check("idle", n, 0);
        sync_input_line <= 1'b1;
        wait_hi("rise", send_strobe, 100);
        check("mark", status_word, 16'h0001);
        wr(sst_pkg::OFS_CTRL, 32'h3);
        sync_input_line <= 1'b0;
        wait_hi("fall", send_strobe, 100);
        $display("test trigger done");
        wr(sst_pkg::OFS_SKIP, 32'h0);
        wr(sst_pkg::OFS_WIDTH, 32'h2);
        wr(sst_pkg::OFS_REF_PER, 32'h1);
        wr(sst_pkg::OFS_CTRL, 32'h48);
        wait_hi("mark", out_mark_valid, 51000);
        wait_hi("pulse", sync_output_line, 2);
        n = 0;
        while (sync_output_line === 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check("width", n, 40);
        wr(sst_pkg::OFS_CTRL, 32'h68);
        repeat (4) @(posedge mclk);
        check("neg idle", sync_output_line, 1'b1);
        wait_hi("lock", drift_locked, 41000);
        rd("bias", sst_pkg::OFS_BIAS, 32'h0);
        rd("status", sst_pkg::OFS_STATUS, 32'h14);
        wr(sst_pkg::OFS_CTRL, 32'h78);
        repeat (4) @(posedge mclk);
        check("toggle idle", sync_output_line, 1'b0);
        $display("test pulse done");
        wr(sst_pkg::OFS_CTRL, 32'h80);
        sampling_start_sync <= 1'b1;
        wait_hi("smp", first_sample, 100);
        wait_hi("imu", first_inertial, 100);
        check("imu gap", n, 10);
        wait_hi("ori", first_orient, 100);
        check("ori gap", n, 20);
        $display("test start done");
        test_done();
    end
endmodule : tb
